// File: rtl/ptmr_pkg.sv
// constants, register map and carrier types of the 8-bit period timer
// assumes one 20 MHz clock and an APB master on the same clock
package ptmr_pkg;

    // clock and instruction-clock derivation
    localparam int unsigned MCLK_HZ = 20_000_000;
    localparam int unsigned INSTR_DIV = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

    // register byte addresses
    localparam logic [7:0] ADDR_PERIOD = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h10;

    // control register fields
    localparam int unsigned CTL_PRE_LSB = 0;
    localparam int unsigned CTL_PRE_W = 2;
    localparam int unsigned CTL_RUN_BIT = 2;
    localparam int unsigned CTL_POST_LSB = 3;
    localparam int unsigned CTL_POST_W = 4;
    localparam int unsigned CTL_W = 7;

    // status and mask field
    localparam int unsigned STAT_MATCH_BIT = 0;

    // prescaler terminal counts
    localparam logic [3:0] PRE_LAST_1 = 4'h0;
    localparam logic [3:0] PRE_LAST_4 = 4'h3;
    localparam logic [3:0] PRE_LAST_16 = 4'hF;

    // reset values
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [6:0] CTL_RESET = 7'h00;
    localparam logic [3:0] POST_RESET = 4'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic [2:0]
    {
        REG_PERIOD,
        REG_COUNT,
        REG_CTRL,
        REG_STAT,
        REG_MASK,
        REG_NONE
    } ptmr_reg_e;

    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ptmr_apb_req_s;

    typedef struct packed
    {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } ptmr_apb_rsp_s;

    // time base handed to the pwm unit
    typedef struct packed
    {
        logic [7:0] count;
        logic [7:0] period;
        logic periodMatch;
    } ptmr_pwm_s;

endpackage : ptmr_pkg

// File: rtl/ptmr_prescaler.sv
// input prescaler: divides run-gated instruction ticks by 1, 4 or 16
// assumes tick and clear are same-clock one-cycle enables
module ptmr_prescaler
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic tick,
    input wire logic clear,
    input wire logic [1:0] select,
    output logic out
);

    typedef struct packed
    {
        logic [3:0] cnt;
    } ptmr_pre_s;

    ptmr_pre_s q;
    ptmr_pre_s d;
    logic [3:0] last;

    always_comb
    begin
        d = q;
        if (select[1])
        begin
            last = ptmr_pkg::PRE_LAST_16;
        end
        else if (select[0])
        begin
            last = ptmr_pkg::PRE_LAST_4;
        end
        else
        begin
            last = ptmr_pkg::PRE_LAST_1;
        end
        // a clearing write swallows the tick so counts restart clean
        out = tick && !clear && (q.cnt == last);
        if (clear)
        begin
            d.cnt = 4'h0;
        end
        else if (out)
        begin
            d.cnt = 4'h0;
        end
        else if (tick)
        begin
            d.cnt = q.cnt + 4'h1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

endmodule : ptmr_prescaler

// File: rtl/ptmr_timer.sv
// 8-bit period timer with prescaler, postscaler, apb registers, irq
// assumes apb master on mclk; pwm unit consumes the timeBase output
module ptmr_timer
(
    input wire logic mclk,
    input wire logic reset,
    input wire ptmr_pkg::ptmr_apb_req_s apbReq,
    output ptmr_pkg::ptmr_apb_rsp_s apbRsp,
    output ptmr_pkg::ptmr_pwm_s timeBase,
    output logic irq
);

    typedef struct packed
    {
        logic [1:0] instrCnt;
        logic [7:0] period;
        logic [7:0] count;
        logic [6:0] ctl;
        logic [3:0] post;
        logic flag;
        logic irqEn;
        logic matchPulse;
        logic [31:0] rdata;
        logic slvErr;
    } ptmr_state_s;

    localparam ptmr_state_s STATE_RESET = '{
        instrCnt: 2'h0,
        period: ptmr_pkg::PERIOD_RESET,
        count: ptmr_pkg::COUNT_RESET,
        ctl: ptmr_pkg::CTL_RESET,
        post: ptmr_pkg::POST_RESET,
        flag: 1'b0,
        irqEn: 1'b0,
        matchPulse: 1'b0,
        rdata: ptmr_pkg::RDATA_RESET,
        slvErr: 1'b0
    };

    ptmr_state_s q;
    ptmr_state_s d;

    logic setup;
    logic access;
    logic wrAccess;
    ptmr_pkg::ptmr_reg_e wrSel;
    logic instrTick;
    logic preTick;
    logic preClear;
    logic preOut;
    logic countWr;
    logic ctlWr;
    logic runEn;
    logic [1:0] preSel;
    logic [3:0] postSel;
    logic periodHit;
    logic postHit;
    logic statWr;
    logic [31:0] rdNext;
    logic addrErr;

    // word-aligned decode; anything else is an error answer
    function automatic ptmr_pkg::ptmr_reg_e regSel(input logic [7:0] addr);
        ptmr_pkg::ptmr_reg_e sel;
        case (addr)
            ptmr_pkg::ADDR_PERIOD: sel = ptmr_pkg::REG_PERIOD;
            ptmr_pkg::ADDR_COUNT: sel = ptmr_pkg::REG_COUNT;
            ptmr_pkg::ADDR_CTRL: sel = ptmr_pkg::REG_CTRL;
            ptmr_pkg::ADDR_STAT: sel = ptmr_pkg::REG_STAT;
            ptmr_pkg::ADDR_MASK: sel = ptmr_pkg::REG_MASK;
            default: sel = ptmr_pkg::REG_NONE;
        endcase
        return sel;
    endfunction : regSel

    // read data is sampled in the setup cycle, one cycle ahead of pready
    function automatic logic [31:0] readMux(
        input ptmr_pkg::ptmr_reg_e sel,
        input ptmr_state_s s
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        case (sel)
            ptmr_pkg::REG_PERIOD: v[7:0] = s.period;
            ptmr_pkg::REG_COUNT: v[7:0] = s.count;
            ptmr_pkg::REG_CTRL: v[6:0] = s.ctl;
            ptmr_pkg::REG_STAT: v[ptmr_pkg::STAT_MATCH_BIT] = s.flag;
            ptmr_pkg::REG_MASK: v[ptmr_pkg::STAT_MATCH_BIT] = s.irqEn;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : readMux

    // terminal-count compare, shared by the reload and the flag path
    function automatic logic atTerminal(
        input logic [7:0] count,
        input logic [7:0] period
    );
        logic hit;
        hit = (count == period);
        return hit;
    endfunction : atTerminal

    // postscaler terminal: sel+1 matches per flag, so code 0 gives 1:1
    function automatic logic postTerminal(
        input logic [3:0] post,
        input logic [3:0] sel
    );
        logic hit;
        hit = (post == sel);
        return hit;
    endfunction : postTerminal

    // postscaler step, wrapping at its terminal
    function automatic logic [3:0] postStep(
        input logic [3:0] post,
        input logic [3:0] sel
    );
        logic [3:0] nxt;
        if (postTerminal(post, sel))
        begin
            nxt = ptmr_pkg::POST_RESET;
        end
        else
        begin
            nxt = post + 4'h1;
        end
        return nxt;
    endfunction : postStep

    // write strobe of one register in the access cycle
    function automatic logic wrHit(
        input logic en,
        input ptmr_pkg::ptmr_reg_e sel,
        input ptmr_pkg::ptmr_reg_e target
    );
        logic hit;
        hit = en && (sel == target);
        return hit;
    endfunction : wrHit

    // free-running mclk/4 divider; register writes never touch it
    function automatic logic [1:0] instrStep(input logic [1:0] cnt);
        logic [1:0] nxt;
        if (cnt == ptmr_pkg::INSTR_LAST)
        begin
            nxt = 2'h0;
        end
        else
        begin
            nxt = cnt + 2'h1;
        end
        return nxt;
    endfunction : instrStep

    // control field views
    assign runEn = q.ctl[ptmr_pkg::CTL_RUN_BIT];
    assign preSel = q.ctl[ptmr_pkg::CTL_PRE_LSB +: ptmr_pkg::CTL_PRE_W];
    assign postSel = q.ctl[ptmr_pkg::CTL_POST_LSB +: ptmr_pkg::CTL_POST_W];

    // bus phases
    assign setup = apbReq.psel && !apbReq.penable;
    assign access = apbReq.psel && apbReq.penable;
    assign wrAccess = access && apbReq.pwrite && !q.slvErr;
    assign wrSel = regSel(apbReq.paddr);
    assign countWr = wrHit(wrAccess, wrSel, ptmr_pkg::REG_COUNT);
    assign ctlWr = wrHit(wrAccess, wrSel, ptmr_pkg::REG_CTRL);
    assign statWr = wrHit(wrAccess, wrSel, ptmr_pkg::REG_STAT);

    // instruction clock is mclk/4 as a one-cycle enable
    assign instrTick = (q.instrCnt == ptmr_pkg::INSTR_LAST);
    assign preTick = instrTick && runEn;
    assign preClear = countWr || ctlWr;

    // match, postscaler terminal and read path decode
    assign periodHit = preOut && atTerminal(q.count, q.period);
    assign postHit = periodHit && postTerminal(q.post, postSel);
    assign rdNext = readMux(wrSel, q);
    assign addrErr = (wrSel == ptmr_pkg::REG_NONE);

    ptmr_prescaler u_prescaler
    (
        .mclk(mclk),
        .reset(reset),
        .tick(preTick),
        .clear(preClear),
        .select(preSel),
        .out(preOut)
    );

    always_comb
    begin
        d = q;
        d.matchPulse = 1'b0;

        // free-running instruction clock divider
        d.instrCnt = instrStep(q.instrCnt);

        // counter advances only on prescaled ticks while running
        if (preOut)
        begin
            if (periodHit)
            begin
                d.count = 8'h00;
                d.matchPulse = 1'b1;
                d.post = postStep(q.post, postSel);
            end
            else
            begin
                d.count = q.count + 8'h01;
            end
        end

        // register setup: capture read data and decode error
        if (setup)
        begin
            d.rdata = rdNext;
            d.slvErr = addrErr;
        end

        // flag clear by writing one; a same-cycle set still wins below
        if (statWr)
        begin
            if (apbReq.pwdata[ptmr_pkg::STAT_MATCH_BIT])
            begin
                d.flag = 1'b0;
            end
        end

        if (wrAccess)
        begin
            case (wrSel)
                ptmr_pkg::REG_PERIOD:
                begin
                    d.period = apbReq.pwdata[7:0];
                end
                ptmr_pkg::REG_COUNT:
                begin
                    // write beats a same-cycle increment
                    d.count = apbReq.pwdata[7:0];
                    d.post = 4'h0;
                end
                ptmr_pkg::REG_CTRL:
                begin
                    // count is left alone on purpose
                    d.ctl = apbReq.pwdata[ptmr_pkg::CTL_W - 1:0];
                    d.post = 4'h0;
                end
                ptmr_pkg::REG_MASK:
                begin
                    d.irqEn = apbReq.pwdata[ptmr_pkg::STAT_MATCH_BIT];
                end
                default:
                begin
                    d.irqEn = q.irqEn;
                end
            endcase
        end

        // postscaler terminal sets the sticky flag
        if (postHit)
        begin
            d.flag = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            q <= STATE_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // zero-wait access phase; data comes from flops
    assign apbRsp.pready = access;
    assign apbRsp.prdata = q.rdata;
    assign apbRsp.pslverr = access && q.slvErr;

    // pwm time base
    assign timeBase.count = q.count;
    assign timeBase.period = q.period;
    assign timeBase.periodMatch = q.matchPulse;

    // level interrupt gated by its enable
    assign irq = q.flag && q.irqEn;

endmodule : ptmr_timer

// File: dv/ptmr_timer_chk.sv
// port checker of the period timer
// assumes it is bound into ptmr_timer
module ptmr_timer_chk
(
    input wire logic mclk,
    input wire logic reset,
    input wire ptmr_pkg::ptmr_apb_req_s apbReq,
    input wire ptmr_pkg::ptmr_apb_rsp_s apbRsp,
    input wire ptmr_pkg::ptmr_pwm_s timeBase,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic acc;
    logic wrAny;
    logic wrCnt;
    logic wrStat;
    logic wrMask;
    logic okAddr;
    logic runQ;
    assign acc = apbReq.psel & apbReq.penable;
    assign wrAny = acc & apbReq.pwrite;
    assign wrCnt = wrAny & (apbReq.paddr == ptmr_pkg::ADDR_COUNT);
    assign wrStat = wrAny & (apbReq.paddr == ptmr_pkg::ADDR_STAT);
    assign wrMask = wrAny & (apbReq.paddr == ptmr_pkg::ADDR_MASK);
    assign okAddr = apbReq.paddr inside {ptmr_pkg::ADDR_PERIOD,
        ptmr_pkg::ADDR_COUNT, ptmr_pkg::ADDR_CTRL, ptmr_pkg::ADDR_STAT,
        ptmr_pkg::ADDR_MASK};
    // shadow of the run bit, the checker cannot see the register
    always_ff @(posedge mclk)
    begin
        if (reset)
            runQ <= 1'b0;
        else if (wrAny && apbReq.paddr == ptmr_pkg::ADDR_CTRL)
            runQ <= apbReq.pwdata[ptmr_pkg::CTL_RUN_BIT];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence apbAcc;
        apbReq.psel && apbReq.penable;
    endsequence
    sequence matchPulse;
        timeBase.count == 8'h00 ##1 !timeBase.periodMatch;
    endsequence
    pready_a: assert property (apbRsp.pready == acc)
        else $error("pready not tied to access");
    bad_addr_a: assert property (apbAcc |-> apbRsp.pslverr == !okAddr)
        else $error("pslverr wrong for address");
    err_idle_a: assert property (!acc |-> !apbRsp.pslverr)
        else $error("pslverr outside access");
    match_zero_a: assert property (timeBase.periodMatch |-> matchPulse)
        else $error("match without zero count or too long");
    count_step_a: assert property ($changed(timeBase.count)
        && !$past(wrCnt) |-> timeBase.count == $past(timeBase.count) + 8'h01
        || timeBase.count == 8'h00) else $error("count jumped");
    halt_a: assert property (!runQ && !wrCnt |=> $stable(timeBase.count))
        else $error("count moved while stopped");
    reset_val_a: assert property ($fell(reset) |->
        timeBase.count == 8'h00 && timeBase.period == 8'hFF)
        else $error("reset values wrong");
    irq_hold_a: assert property (irq && !wrStat && !wrMask |=> irq)
        else $error("irq dropped by itself");
    irq_cause_a: assert property ($rose(irq) && !$past(wrMask) |->
        $past(timeBase.periodMatch) or ##[0:1] timeBase.periodMatch)
        else $error("irq rose without match");
endmodule : ptmr_timer_chk

bind ptmr_timer ptmr_timer_chk u_chk
(
    .mclk(mclk),
    .reset(reset),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .timeBase(timeBase),
    .irq(irq)
);

// File: dv/tb_top.sv
// self-checking bench of the period timer through apb
// assumes the checker is bound by its own file
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk;
    logic reset;
    ptmr_pkg::ptmr_apb_req_s req;
    ptmr_pkg::ptmr_apb_rsp_s rsp;
    ptmr_pkg::ptmr_pwm_s tb;
    logic irq;
    logic [31:0] rdData;
    logic rdErr;
    int errors;
    int totalChecks;
    int cyc;
    ptmr_timer DUT
    (
        .mclk(mclk),
        .reset(reset),
        .apbReq(req),
        .apbRsp(rsp),
        .timeBase(tb),
        .irq(irq)
    );
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        @(posedge mclk);
        while (rsp.pready !== 1'b1)
            @(posedge mclk);
        rdData = rsp.prdata;
        rdErr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic wait_match(output int n);
        n = 1;
        @(posedge mclk);
        while (tb.periodMatch !== 1'b1)
        begin
            n++;
            @(posedge mclk);
        end
    endtask : wait_match
    task automatic t_reset;
        apb(1'b0, ptmr_pkg::ADDR_PERIOD, '0);
        chk(rdData, 32'h0000_00FF);
        apb(1'b0, ptmr_pkg::ADDR_COUNT, '0);
        chk(rdData, 32'h0000_0000);
        apb(1'b0, ptmr_pkg::ADDR_MASK, '0);
        chk(rdData, 32'h0000_0000);
    endtask : t_reset
    task automatic t_regs;
        apb(1'b1, ptmr_pkg::ADDR_PERIOD, 32'h0000_005A);
        apb(1'b1, 8'h14, 32'h0000_0011);
        chk(32'({rdErr, tb.period}), 32'h0000_015A);
        apb(1'b1, ptmr_pkg::ADDR_CTRL, 32'h0000_00FB);
        apb(1'b0, ptmr_pkg::ADDR_CTRL, '0);
        chk(rdData, 32'h0000_007B);
        apb(1'b1, ptmr_pkg::ADDR_COUNT, 32'h0000_0033);
        repeat (20) @(posedge mclk);
        apb(1'b0, ptmr_pkg::ADDR_COUNT, '0);
        chk(rdData, 32'h0000_0033);
    endtask : t_regs
    task automatic t_pre;
        int n;
        apb(1'b1, ptmr_pkg::ADDR_PERIOD, 32'h0000_0002);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, ptmr_pkg::ADDR_CTRL, 32'h0000_0004 | c);
            wait_match(n);
            wait_match(n);
            // three counts per period, instruction tick is mclk over four
            chk(n, 12 * (c == 0 ? 1 : c == 1 ? 4 : 16));
        end
    endtask : t_pre
    task automatic t_post;
        int k;
        apb(1'b1, ptmr_pkg::ADDR_PERIOD, '0);
        apb(1'b1, ptmr_pkg::ADDR_MASK, 32'h0000_0001);
        for (int n = 0; n < 16; n++)
        begin
            apb(1'b1, ptmr_pkg::ADDR_CTRL, n << 3);
            apb(1'b1, ptmr_pkg::ADDR_STAT, 32'h0000_0001);
            apb(1'b1, ptmr_pkg::ADDR_CTRL, (n << 3) | 4);
            k = 0;
            do
            begin
                @(posedge mclk);
                k += (tb.periodMatch === 1'b1);
            end
            while (irq !== 1'b1);
            // flag and match pulse rise on the same edge, so this sample adds no match
            @(posedge mclk);
            k += (tb.periodMatch === 1'b1);
            chk(k, n + 1);
        end
    endtask : t_post
    task automatic t_irq;
        apb(1'b1, ptmr_pkg::ADDR_CTRL, '0);
        apb(1'b1, ptmr_pkg::ADDR_MASK, '0);
        #1 chk(irq, 1'b0);
        apb(1'b1, ptmr_pkg::ADDR_STAT, '0);
        apb(1'b0, ptmr_pkg::ADDR_STAT, '0);
        chk(rdData, 32'h0000_0001);
        apb(1'b1, ptmr_pkg::ADDR_MASK, 32'h0000_0001);
        #1 chk(irq, 1'b1);
        apb(1'b1, ptmr_pkg::ADDR_STAT, 32'h0000_0001);
        #1 chk(irq, 1'b0);
    endtask : t_irq
    task final_report;
        $display("errors=%0d checks=%0d", errors, totalChecks);
        if (errors == 0 && totalChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    // ceiling well above the fewer than three thousand cycles the tasks need
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            final_report();
        end
    end
    initial
    begin
        reset = 1'b1;
        req = '0;
        errors = 0;
        totalChecks = 0;
        cyc = 0;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_pre();
        t_post();
        t_irq();
        final_report();
    end
endmodule : tb_top
